// ---- common/mbts_defines.vh ----
// constants for the motion block transition sequencer
`ifndef MBTS_DEFINES_VH
`define MBTS_DEFINES_VH
`define MBTS_CLK_KHZ 100000
`define MBTS_INPOS_START_MS 4
`define MBTS_ADDR_CTRL 8'h00
`define MBTS_ADDR_MAXFEED 8'h04
`define MBTS_ADDR_ACCT 8'h08
`define MBTS_ADDR_DECT 8'h0C
`define MBTS_ADDR_STATUS 8'h10
`define MBTS_ADDR_RAMP 8'h14
`define MBTS_CTRL_DECSEL 0
`define MBTS_CTRL_CONSTACC 1
`define MBTS_CTRL_SCURVE 2
`define MBTS_STAT_SLOW 6
`define MBTS_CTRL_RST 3'h0
`define MBTS_MAXFEED_RST 16'h03E8
`define MBTS_ACCT_RST 16'h0064
`define MBTS_DECT_RST 16'h0064
`define MBTS_K_LIN 4'h0
`define MBTS_K_CIRC 4'h1
`define MBTS_K_TRAV 4'h2
`define MBTS_K_PTP 4'h3
`define MBTS_K_DWELL 4'h4
`define MBTS_K_ORGUNDEF 4'h5
`define MBTS_K_SPEED 4'h6
`define MBTS_K_INTFEED 4'h7
`define MBTS_K_COORD 4'h8
`define MBTS_K_PEND 4'h9
`define MBTS_K_MDCODE 4'hA
`define MBTS_K_PASSCMD 4'hB
`define MBTS_K_STOPCMD 4'hC
`define MBTS_K_INPOSCMD 4'hD
`define MBTS_K_PARAMCMD 4'hE
`define MBTS_MODE_PASS 2'h0
`define MBTS_MODE_STOP 2'h1
`define MBTS_MODE_INPOS 2'h2
`define MBTS_W_INPOS 2'h0
`define MBTS_W_DEMAND 2'h1
`define MBTS_W_ACC 2'h2
`define MBTS_W_DEC 2'h3
`define MBTS_RATE_SHIFT 8
`endif

// ---- verilog/mbts_sequencer.v ----
// motion block transition sequencer: pass/stop decision, ramp math and block release
//
// Behaviour
// - pass-time select acceleration: next block starts in previous block's acceleration interval
// - pass-time select deceleration: next block starts in previous block's deceleration interval
// - pass handover always uses trapezoid profile, even with s-curve configured
// - constant acceleration only when enabled and block is single-axis linear
// - acceleration rate is max feed over accel time; deceleration likewise
// - ramp time is feed change times accel or decel time over max feed
// - ramp times come from system settings or latest parameter change command
// - constant acceleration: next linear block waits until demand position generated
// - in-position-check-off: next block starts without positioning complete, within 4 ms
// - after stop-mode command, each block waits for positioning complete
// - multi-axis move after constant-acceleration linear waits for positioning complete
// - constant acceleration pass: axes with zero relative movement are not moved
// - linear after motion, motion after linear, same-plane circles pass
// - circle after circle in another plane waits for completion
// - traverse after circle or circle after traverse uses stop behaviour
// - traverse after traverse same axes: stop on reversal, pass otherwise
// - traverse after traverse on other axes finishes first pair before second
// - pass and check-off modes read ahead; halted read-ahead means stop behaviour
// - linear or circular block with low auxiliary code halts read-ahead after it
// - listed non-interpolation, option-number and standalone code blocks stop predecessor
// - pass mode is selected after reset
// - constant acceleration overrides pass-time select for single-axis passes
//
// Our own choices: the register addresses and the APB register port.
`include "mbts_defines.vh"
module mbts_sequencer #(
  parameter FEED_W = 16,
  parameter TIME_W = 16,
  parameter INPOS_START_CYC = `MBTS_INPOS_START_MS * `MBTS_CLK_KHZ
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [7:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire blk_valid,
  input wire [3:0] blk_kind,
  input wire [3:0] blk_axes,
  input wire [3:0] blk_zero,
  input wire [1:0] blk_plane,
  input wire [3:0] blk_dir,
  input wire [FEED_W-1:0] blk_feed,
  input wire blk_mlo,
  input wire blk_opt,
  input wire [TIME_W-1:0] blk_acct,
  input wire [TIME_W-1:0] blk_dect,
  output reg blk_ready,
  input wire gen_accel,
  input wire gen_decel,
  input wire gen_demand_done,
  input wire gen_inpos,
  output reg traj_start,
  output reg [3:0] traj_kind,
  output reg [3:0] traj_axes,
  output reg [1:0] traj_plane,
  output reg [3:0] traj_dir,
  output reg [FEED_W-1:0] traj_feed,
  output reg [31:0] traj_ramp,
  output reg [31:0] traj_acc_rate,
  output reg [31:0] traj_dec_rate,
  output reg traj_const_acc,
  output reg traj_scurve,
  output reg traj_pass
);
  localparam ST_IDLE = 2'h0;
  localparam ST_DECIDE = 2'h1;
  localparam ST_DIV = 2'h2;
  localparam ST_WAIT = 2'h3;

  reg [1:0] st_r;
  reg [1:0] mode_r;
  reg [2:0] ctrl_r;
  reg [FEED_W-1:0] maxfeed_r;
  reg [TIME_W-1:0] acct_r;
  reg [TIME_W-1:0] dect_r;
  reg slow_r;
  reg [19:0] slow_cnt_r;
  // block under decision
  reg [3:0] c_kind_r;
  reg [3:0] c_axes_r;
  reg [1:0] c_plane_r;
  reg [3:0] c_dir_r;
  reg [FEED_W-1:0] c_feed_r;
  reg c_mlo_r;
  reg c_opt_r;
  reg c_ca_r;
  reg [1:0] c_wait_r;
  // block last released
  reg p_valid_r;
  reg [3:0] p_kind_r;
  reg [3:0] p_axes_r;
  reg [1:0] p_plane_r;
  reg [3:0] p_dir_r;
  reg [FEED_W-1:0] p_feed_r;
  reg p_mlo_r;
  reg p_ca_r;
  // shared serial divider
  reg [1:0] phase_r;
  reg [4:0] cnt_r;
  reg [31:0] num_r;
  reg [TIME_W-1:0] den_r;
  reg [TIME_W:0] rem_r;
  reg [31:0] quo_r;
  reg [31:0] ramp_r;
  reg [31:0] accr_r;

  wire apb_wr = psel & penable & pready & pwrite;
  wire apb_rd_setup = psel & ~penable;

  // block classification
  wire [3:0] eff_axes = ctrl_r[`MBTS_CTRL_CONSTACC] ? (blk_axes & ~blk_zero) : blk_axes;
  wire eff_single = (eff_axes != 4'h0) && ((eff_axes & (eff_axes - 4'h1)) == 4'h0);
  wire c_interp = (c_kind_r == `MBTS_K_LIN) | (c_kind_r == `MBTS_K_CIRC) | (c_kind_r == `MBTS_K_TRAV);
  wire p_interp = p_valid_r & ((p_kind_r == `MBTS_K_LIN) | (p_kind_r == `MBTS_K_CIRC) |
                  (p_kind_r == `MBTS_K_TRAV));
  wire c_multi = (c_axes_r & (c_axes_r - 4'h1)) != 4'h0;
  wire c_cmd = (c_kind_r >= `MBTS_K_PASSCMD);

  reg table_pass;
  always @* begin
    table_pass = 1'b0;
    if (p_interp && c_interp) begin
      if (c_kind_r == `MBTS_K_LIN || p_kind_r == `MBTS_K_LIN)
        table_pass = 1'b1;
      else if (p_kind_r == `MBTS_K_CIRC && c_kind_r == `MBTS_K_CIRC)
        table_pass = (p_plane_r == c_plane_r);
      else if (p_kind_r == `MBTS_K_TRAV && c_kind_r == `MBTS_K_TRAV)
        table_pass = (p_axes_r == c_axes_r) && ((p_dir_r & c_axes_r) == (c_dir_r & c_axes_r));
      else
        table_pass = 1'b0;
    end
  end

  // read-ahead is halted by a low auxiliary code behind, or a stop-before block ahead
  wire halt_ahead = p_mlo_r | (c_interp & c_opt_r) | ~c_interp;
  wire after_ca_multi = p_valid_r & p_ca_r & c_multi;

  reg [1:0] wait_sel;
  always @* begin
    wait_sel = `MBTS_W_INPOS;
    case (mode_r)
      `MBTS_MODE_PASS: begin
        if (halt_ahead || after_ca_multi || !table_pass)
          wait_sel = `MBTS_W_INPOS;
        else if (c_ca_r && p_ca_r)
          wait_sel = `MBTS_W_DEMAND;
        else if (ctrl_r[`MBTS_CTRL_DECSEL])
          wait_sel = `MBTS_W_DEC;
        else
          wait_sel = `MBTS_W_ACC;
      end
      `MBTS_MODE_INPOS: begin
        if (halt_ahead || after_ca_multi)
          wait_sel = `MBTS_W_INPOS;
        else
          wait_sel = `MBTS_W_DEMAND;
      end
      default: wait_sel = `MBTS_W_INPOS;
    endcase
  end

  wire is_pass = (c_wait_r == `MBTS_W_ACC) | (c_wait_r == `MBTS_W_DEC) |
                 ((c_wait_r == `MBTS_W_DEMAND) & (mode_r == `MBTS_MODE_PASS));
  wire rising = c_feed_r >= p_feed_r;
  wire [FEED_W-1:0] dfeed = ~is_pass ? c_feed_r : (rising ? c_feed_r - p_feed_r : p_feed_r - c_feed_r);
  wire [TIME_W-1:0] rtime = (~is_pass | rising) ? acct_r : dect_r;
  wire [31:0] ramp_num = dfeed * rtime;
  wire [31:0] rate_num = {{(32-FEED_W-`MBTS_RATE_SHIFT){1'b0}}, maxfeed_r, {`MBTS_RATE_SHIFT{1'b0}}};

  wire [TIME_W:0] rem_sh = {rem_r[TIME_W-1:0], num_r[31]};
  wire rem_ge = rem_sh >= {1'b0, den_r};

  reg launch_ok;
  always @* begin
    case (c_wait_r)
      `MBTS_W_DEMAND: launch_ok = gen_demand_done;
      `MBTS_W_ACC: launch_ok = gen_accel | gen_inpos;
      `MBTS_W_DEC: launch_ok = gen_decel | gen_inpos;
      default: launch_ok = gen_inpos;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= ST_IDLE;
      mode_r <= `MBTS_MODE_PASS;
      blk_ready <= 1'b0;
      c_kind_r <= 4'h0;
      c_axes_r <= 4'h0;
      c_plane_r <= 2'h0;
      c_dir_r <= 4'h0;
      c_feed_r <= {FEED_W{1'b0}};
      c_mlo_r <= 1'b0;
      c_opt_r <= 1'b0;
      c_ca_r <= 1'b0;
      c_wait_r <= `MBTS_W_INPOS;
      p_valid_r <= 1'b0;
      p_kind_r <= 4'h0;
      p_axes_r <= 4'h0;
      p_plane_r <= 2'h0;
      p_dir_r <= 4'h0;
      p_feed_r <= {FEED_W{1'b0}};
      p_mlo_r <= 1'b0;
      p_ca_r <= 1'b0;
      phase_r <= 2'h0;
      cnt_r <= 5'h0;
      num_r <= 32'h0;
      den_r <= {TIME_W{1'b0}};
      rem_r <= {(TIME_W+1){1'b0}};
      quo_r <= 32'h0;
      ramp_r <= 32'h0;
      accr_r <= 32'h0;
      traj_start <= 1'b0;
      traj_kind <= 4'h0;
      traj_axes <= 4'h0;
      traj_plane <= 2'h0;
      traj_dir <= 4'h0;
      traj_feed <= {FEED_W{1'b0}};
      traj_ramp <= 32'h0;
      traj_acc_rate <= 32'h0;
      traj_dec_rate <= 32'h0;
      traj_const_acc <= 1'b0;
      traj_scurve <= 1'b0;
      traj_pass <= 1'b0;
      acct_r <= `MBTS_ACCT_RST;
      dect_r <= `MBTS_DECT_RST;
    end else begin
      traj_start <= 1'b0;
      if (apb_wr && paddr == `MBTS_ADDR_ACCT)
        acct_r <= pwdata[TIME_W-1:0];
      if (apb_wr && paddr == `MBTS_ADDR_DECT)
        dect_r <= pwdata[TIME_W-1:0];
      case (st_r)
        ST_IDLE: begin
          blk_ready <= 1'b1;
          if (blk_valid && blk_ready) begin
            blk_ready <= 1'b0;
            c_kind_r <= blk_kind;
            c_axes_r <= eff_axes;
            c_plane_r <= blk_plane;
            c_dir_r <= blk_dir;
            c_feed_r <= blk_feed;
            c_mlo_r <= blk_mlo & ((blk_kind == `MBTS_K_LIN) | (blk_kind == `MBTS_K_CIRC));
            c_opt_r <= blk_opt;
            c_ca_r <= ctrl_r[`MBTS_CTRL_CONSTACC] & (blk_kind == `MBTS_K_LIN) & eff_single;
            if (blk_kind == `MBTS_K_PARAMCMD) begin
              acct_r <= blk_acct;
              dect_r <= blk_dect;
            end
            st_r <= ST_DECIDE;
          end
        end
        ST_DECIDE: begin
          if (c_cmd) begin
            if (c_kind_r == `MBTS_K_PASSCMD)
              mode_r <= `MBTS_MODE_PASS;
            if (c_kind_r == `MBTS_K_STOPCMD)
              mode_r <= `MBTS_MODE_STOP;
            if (c_kind_r == `MBTS_K_INPOSCMD)
              mode_r <= `MBTS_MODE_INPOS;
            st_r <= ST_IDLE;
          end else begin
            c_wait_r <= wait_sel;
            st_r <= ST_DIV;
            cnt_r <= 5'h0;
            rem_r <= {(TIME_W+1){1'b0}};
            num_r <= 32'h0;
            den_r <= {{(TIME_W-FEED_W){1'b0}}, maxfeed_r};
            phase_r <= 2'h3;
          end
        end
        ST_DIV: begin
          // one quotient bit per cycle; a zero divisor saturates the quotient
          if (phase_r == 2'h3) begin
            num_r <= ramp_num;
            den_r <= {{(TIME_W-FEED_W){1'b0}}, maxfeed_r};
            rem_r <= {(TIME_W+1){1'b0}};
            cnt_r <= 5'h0;
            phase_r <= 2'h0;
          end else begin
            num_r <= {num_r[30:0], 1'b0};
            rem_r <= rem_ge ? rem_sh - {1'b0, den_r} : rem_sh;
            quo_r <= {quo_r[30:0], rem_ge};
            cnt_r <= cnt_r + 5'h1;
            if (cnt_r == 5'h1F) begin
              cnt_r <= 5'h0;
              rem_r <= {(TIME_W+1){1'b0}};
              num_r <= rate_num;
              if (phase_r == 2'h0) begin
                ramp_r <= {quo_r[30:0], rem_ge};
                den_r <= acct_r;
                phase_r <= 2'h1;
              end else if (phase_r == 2'h1) begin
                accr_r <= {quo_r[30:0], rem_ge};
                den_r <= dect_r;
                phase_r <= 2'h2;
              end else begin
                traj_dec_rate <= {quo_r[30:0], rem_ge};
                traj_acc_rate <= accr_r;
                traj_ramp <= ramp_r;
                st_r <= ST_WAIT;
              end
            end
          end
        end
        ST_WAIT: begin
          if (!p_valid_r || launch_ok) begin
            traj_start <= 1'b1;
            traj_kind <= c_kind_r;
            traj_axes <= c_axes_r;
            traj_plane <= c_plane_r;
            traj_dir <= c_dir_r;
            traj_feed <= c_feed_r;
            traj_const_acc <= c_ca_r;
            traj_pass <= is_pass & p_valid_r;
            traj_scurve <= ctrl_r[`MBTS_CTRL_SCURVE] & ~(is_pass & p_valid_r);
            p_valid_r <= 1'b1;
            p_kind_r <= c_kind_r;
            p_axes_r <= c_axes_r;
            p_plane_r <= c_plane_r;
            p_dir_r <= c_dir_r;
            p_feed_r <= c_feed_r;
            p_mlo_r <= c_mlo_r;
            p_ca_r <= c_ca_r;
            st_r <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // start-latency watch for check-off mode: counts from demand done until release
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      slow_r <= 1'b0;
      slow_cnt_r <= 20'h0;
    end else begin
      if (st_r != ST_IDLE && mode_r == `MBTS_MODE_INPOS && gen_demand_done && p_valid_r)
        slow_cnt_r <= slow_cnt_r + 20'h1;
      else
        slow_cnt_r <= 20'h0;
      if (slow_cnt_r >= INPOS_START_CYC[19:0])
        slow_r <= 1'b1;
      else if (apb_wr && paddr == `MBTS_ADDR_STATUS && pwdata[`MBTS_STAT_SLOW])
        slow_r <= 1'b0;
    end
  end

  // apb slave: one wait-free access phase, unmapped addresses answer with an error
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      ctrl_r <= `MBTS_CTRL_RST;
      maxfeed_r <= `MBTS_MAXFEED_RST;
    end else begin
      pready <= apb_rd_setup;
      pslverr <= 1'b0;
      prdata <= 32'h0;
      if (apb_rd_setup) begin
        case (paddr)
          `MBTS_ADDR_CTRL: prdata <= {29'h0, ctrl_r};
          `MBTS_ADDR_MAXFEED: prdata <= {{(32-FEED_W){1'b0}}, maxfeed_r};
          `MBTS_ADDR_ACCT: prdata <= {{(32-TIME_W){1'b0}}, acct_r};
          `MBTS_ADDR_DECT: prdata <= {{(32-TIME_W){1'b0}}, dect_r};
          `MBTS_ADDR_STATUS: prdata <= {24'h0, p_ca_r, slow_r, c_wait_r, st_r, mode_r};
          `MBTS_ADDR_RAMP: prdata <= ramp_r;
          default: pslverr <= 1'b1;
        endcase
      end
      if (apb_wr && paddr == `MBTS_ADDR_CTRL)
        ctrl_r <= pwdata[2:0];
      if (apb_wr && paddr == `MBTS_ADDR_MAXFEED)
        maxfeed_r <= pwdata[FEED_W-1:0];
    end
  end
endmodule // mbts_sequencer

// ---- verification/mbts_sequencer_properties.sv ----
// port checker for the block transition sequencer
`include "mbts_defines.vh"
module mbts_seq_props (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire blk_valid,
  input wire [3:0] blk_kind,
  input wire blk_ready,
  input wire gen_accel,
  input wire gen_decel,
  input wire gen_demand_done,
  input wire gen_inpos,
  input wire traj_start,
  input wire [3:0] traj_kind,
  input wire [3:0] traj_axes,
  input wire traj_const_acc,
  input wire traj_scurve,
  input wire traj_pass
);
  timeunit 1ns;
  timeprecision 1ps;
  // the very first block has no predecessor to wait for
  reg started_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) started_r <= 1'b0;
    else if (traj_start) started_r <= 1'b1;
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_one_wait: assert property (psel && !penable |=> pready && penable) else $error("no answer after setup");
  a_ready_single: assert property (pready |=> !pready) else $error("pready longer than one cycle");
  a_idle_quiet: assert property (!pready |-> prdata == 32'h0 && !pslverr) else $error("read data outside access");
  a_start_cause: assert property (traj_start |-> !started_r || $past(gen_accel || gen_decel || gen_demand_done || gen_inpos)) else $error("start without wait cause");
  a_start_pulse: assert property (traj_start |=> !traj_start && blk_ready) else $error("start not a pulse");
  a_take_busy: assert property (blk_valid && blk_ready && blk_kind <= `MBTS_K_TRAV |=> (!blk_ready && !traj_start) [*8]) else $error("block released too early");
  a_held_out: assert property (!traj_start |-> $stable(traj_kind) && $stable(traj_pass) && $stable(traj_axes)) else $error("outputs moved between starts");
  a_nonint_stop: assert property (traj_start && traj_kind > `MBTS_K_TRAV |-> !traj_pass) else $error("pass on listed block");
  a_pass_trap: assert property (traj_start && traj_pass |-> !traj_scurve) else $error("s-curve during pass");
  a_const_single: assert property (traj_start && traj_const_acc |-> traj_kind == `MBTS_K_LIN && $onehot0(traj_axes)) else $error("constant acceleration on wrong move");
endmodule // mbts_seq_props
bind mbts_sequencer mbts_seq_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .blk_valid(blk_valid), .blk_kind(blk_kind),
  .blk_ready(blk_ready), .gen_accel(gen_accel), .gen_decel(gen_decel), .gen_demand_done(gen_demand_done),
  .gen_inpos(gen_inpos), .traj_start(traj_start), .traj_kind(traj_kind), .traj_axes(traj_axes),
  .traj_const_acc(traj_const_acc), .traj_scurve(traj_scurve), .traj_pass(traj_pass));

// ---- verification/mbts_gen_model.sv ----
// trajectory generator stand-in reporting ramp intervals back to the sequencer
module mbts_gen_model (
  input wire pclk,
  input wire presetn,
  input wire traj_start,
  input wire slow,
  output wire gen_accel,
  output wire gen_decel,
  output wire gen_demand_done,
  output wire gen_inpos
);
  timeunit 1ns;
  timeprecision 1ps;
  reg [9:0] cnt_r;
  // slow makes every interval 60 cycles; the windows from decel on open after the divider, so their wait is real
  wire [9:0] t = slow ? 10'h03C : 10'h00C;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt_r <= 10'h000;
    else if (traj_start) cnt_r <= 10'h000;
    else if (cnt_r < 10'h005 * t) cnt_r <= cnt_r + 10'h001;
  end
  assign gen_accel = cnt_r >= t && cnt_r < 10'h002 * t;
  assign gen_decel = cnt_r >= 10'h003 * t && cnt_r < 10'h004 * t;
  assign gen_demand_done = cnt_r >= 10'h004 * t;
  assign gen_inpos = cnt_r >= 10'h005 * t;
endmodule // mbts_gen_model

// ---- verification/mbts_sequencer_bench.sv ----
// self-checking bench for the block transition sequencer
`include "mbts_defines.vh"
module mbts_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] KL = `MBTS_K_LIN;
  localparam logic [3:0] KC = `MBTS_K_CIRC;
  localparam logic [3:0] KT = `MBTS_K_TRAV;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, blk_valid = 0, blk_mlo = 0, blk_opt = 0, slow = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, traj_ramp, traj_acc_rate, traj_dec_rate, q;
  logic [3:0] blk_kind = 4'h0, blk_axes = 4'h0, blk_zero = 4'h0, blk_dir = 4'h0, traj_kind, traj_axes, traj_dir;
  logic [1:0] blk_plane = 2'h0, traj_plane;
  logic [15:0] blk_feed = 16'h0, blk_acct = 16'h00C8, blk_dect = 16'h0032, traj_feed;
  logic pready, pslverr, blk_ready, traj_start, traj_const_acc, traj_scurve, traj_pass, e;
  wire gen_accel, gen_decel, gen_demand_done, gen_inpos;
  int bad_count = 0, n_compared = 0, k;
  mbts_sequencer #(.INPOS_START_CYC(50)) uut (.*);
  mbts_gen_model u_gen (.*);
  always #5 pclk = ~pclk;
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string w, input logic [31:0] x, input logic [31:0] g);
    n_compared++;
    if (g !== x) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", w, x, g);
    end
  endtask
  task automatic hang(input string w);
    bad_count++;
    $display("unexpected %s: no answer", w);
    end_of_test();
  endtask
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin @(posedge pclk); i++; end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) hang("pready");
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] x, input string w);
    apb(1'b0, a, 32'h0);
    chk(w, x, q & m);
    chk("pslverr", 32'h0, e);
  endtask
  // x packs {option, low m code, zero-move axes}; ep 2 leaves the pass flag unjudged
  task automatic blk(input logic [3:0] kd, input logic [3:0] ax, input logic [1:0] pl, input logic [3:0] dr,
                     input logic [15:0] f, input logic [5:0] x, input logic [1:0] ep);
    int i;
    @(posedge pclk);
    blk_valid <= 1'b1;
    blk_kind <= kd;
    blk_axes <= ax;
    blk_plane <= pl;
    blk_dir <= dr;
    blk_feed <= f;
    blk_opt <= x[5];
    blk_mlo <= x[4];
    blk_zero <= x[3:0];
    i = 0;
    do begin @(posedge pclk); i++; end while (blk_ready !== 1'b1 && i < 600);
    blk_valid <= 1'b0;
    if (blk_ready !== 1'b1) hang("blk_ready");
    if (kd < `MBTS_K_PASSCMD) begin
      i = 0;
      do begin @(negedge pclk); i++; end while (traj_start !== 1'b1 && i < 2000);
      if (traj_start !== 1'b1) hang("traj_start");
      chk("traj_kind", kd, traj_kind);
      chk("traj_feed", f, traj_feed);
      chk("traj_dir", dr, traj_dir);
      chk("traj_plane", pl, traj_plane);
      if (ep < 2'h2) chk("traj_pass", ep[0], traj_pass);
    end
  endtask
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MBTS_ADDR_CTRL, 32'h7, 32'h0, "ctrl");
    rd(`MBTS_ADDR_MAXFEED, 32'hFFFF, 32'h3E8, "maxfeed");
    rd(`MBTS_ADDR_ACCT, 32'hFFFF, 32'h64, "acct");
    rd(`MBTS_ADDR_STATUS, 32'h3, 32'h0, "mode");
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped err", 32'h1, e);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h00C8, 6'h00, 2'h2);
    chk("ramp", 32'h14, traj_ramp);
    chk("acc_rate", 32'hA00, traj_acc_rate);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h1);
    chk("ramp", 32'h1E, traj_ramp);
    blk(KC, 4'h3, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h1);
    blk(KC, 4'h3, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h1);
    blk(KC, 4'h3, 2'h1, 4'h0, 16'h01F4, 6'h00, 2'h0);
    blk(KT, 4'h3, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h0);
    blk(KT, 4'h3, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h1);
    blk(KT, 4'h3, 2'h0, 4'h3, 16'h01F4, 6'h00, 2'h0);
    blk(KT, 4'hC, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h0);
    blk(KC, 4'h3, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h0);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h01F4, 6'h10, 2'h1);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h0);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h01F4, 6'h20, 2'h0);
    for (k = 3; k <= 10; k++) blk(k[3:0], 4'h1, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h0);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h01F4, 6'h00, 2'h2);
    // slow intervals: the divider ends inside the accel window, well before the decel window
    slow <= 1'b1;
    apb(1'b1, `MBTS_ADDR_CTRL, 32'h4);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h0320, 6'h00, 2'h1);
    chk("scurve", 32'h0, traj_scurve);
    chk("accel window", 32'h1, gen_accel);
    apb(1'b1, `MBTS_ADDR_CTRL, 32'h1);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h012C, 6'h00, 2'h1);
    chk("decel window", 32'h1, gen_decel);
    slow <= 1'b0;
    apb(1'b1, `MBTS_ADDR_CTRL, 32'h0);
    blk(`MBTS_K_PARAMCMD, 4'h0, 2'h0, 4'h0, 16'h0, 6'h00, 2'h2);
    rd(`MBTS_ADDR_ACCT, 32'hFFFF, 32'hC8, "acct");
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h012C, 6'h00, 2'h2);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h0064, 6'h00, 2'h1);
    chk("ramp", 32'hA, traj_ramp);
    chk("acc_rate", 32'h500, traj_acc_rate);
    chk("dec_rate", 32'h1400, traj_dec_rate);
    apb(1'b1, `MBTS_ADDR_CTRL, 32'h3);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h00C8, 6'h00, 2'h2);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h0190, 6'h00, 2'h1);
    chk("const_acc", 32'h1, traj_const_acc);
    blk(KL, 4'h3, 2'h0, 4'h0, 16'h0190, 6'h00, 2'h0);
    chk("const_acc", 32'h0, traj_const_acc);
    blk(KL, 4'h3, 2'h0, 4'h0, 16'h0190, 6'h02, 2'h1);
    chk("axes", 32'h1, traj_axes);
    // slow intervals separate demand done from positioning complete at the launch
    slow <= 1'b1;
    blk(`MBTS_K_STOPCMD, 4'h0, 2'h0, 4'h0, 16'h0, 6'h00, 2'h2);
    rd(`MBTS_ADDR_STATUS, 32'h3, 32'h1, "mode");
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h0190, 6'h00, 2'h0);
    chk("inpos at start", 32'h1, gen_inpos);
    blk(`MBTS_K_INPOSCMD, 4'h0, 2'h0, 4'h0, 16'h0, 6'h00, 2'h2);
    rd(`MBTS_ADDR_STATUS, 32'h3, 32'h2, "mode");
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h0190, 6'h10, 2'h2);
    chk("inpos at start", 32'h0, gen_inpos);
    chk("demand at start", 32'h1, gen_demand_done);
    blk(KL, 4'h1, 2'h0, 4'h0, 16'h0190, 6'h00, 2'h0);
    chk("inpos at start", 32'h1, gen_inpos);
    blk(`MBTS_K_PASSCMD, 4'h0, 2'h0, 4'h0, 16'h0, 6'h00, 2'h2);
    rd(`MBTS_ADDR_STATUS, 32'h3, 32'h0, "mode");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rd(`MBTS_ADDR_DECT, 32'hFFFF, 32'h64, "dect");
    rd(`MBTS_ADDR_STATUS, 32'h3, 32'h0, "mode");
    end_of_test();
  end
endmodule // mbts_sequencer_bench
